// ===== hw/mec_cfg.svh
// offsets, field positions, reset values for the error capture bank
`ifndef MEC_CFG_SVH
`define MEC_CFG_SVH

// register byte offsets
`define MEC_OFS_ENABLE      16'h100c
`define MEC_OFS_ADDR_CAP    16'h1014
`define MEC_OFS_SOURCE_ID_LOW_BYTE_CAP   16'h1018
`define MEC_OFS_CTRL_CAP    16'h101c
`define MEC_OFS_INT_STATUS  16'h1030
`define MEC_OFS_INT_MASK    16'h1034

// address capture fields (bit 0 is the msb in the map)
`define MEC_ADDR_HI         23
`define MEC_ADDR_LO         3
`define MEC_WORD_POINTER_BIT       1
`define MEC_ADDR_CAP_MASK   32'h00fffffa

// source id capture fields
`define MEC_SRC_MSB_HI      15
`define MEC_SRC_MSB_LO      8
`define MEC_SRC_LSB_HI      7
`define MEC_SRC_LSB_LO      0
`define MEC_SOURCE_ID_LOW_BYTE_CAP_MASK  32'h0000ffff

// control capture fields
`define MEC_FTYPE_HI        31
`define MEC_FTYPE_LO        28
`define MEC_TTYPE_HI        27
`define MEC_TTYPE_LO        24
`define MEC_CTRL_CAP_MASK   32'hff000000

// enable bits in the enable register
`define MEC_EN_ILL_TRANS    27
`define MEC_EN_ILL_RESP     23
`define MEC_EN_UNSUP_TRANS  22

// packet codes
`define MEC_FTYPE_MAINT     4'h8
`define MEC_HOP_TERMINATE   8'h00
`define MEC_TTYPE_RD_RESP   4'h2
`define MEC_TTYPE_WR_RESP   4'h3
`define MEC_TTYPE_PORT_WR   4'h4
`define MEC_TTYPE_FIRST_BAD 4'h5
`define MEC_TT_SMALL        2'h0
`define MEC_TT_LARGE        2'h1

// reset values
`define MEC_RST_WORD        32'h00000000
`define MEC_RST_VEC         4'h0

`endif

// ===== hw/mec_pkg.sv
// types shared by the error capture bank
package mec_pkg;

    // header fields of a packet seen by the logical layer
    typedef struct packed {
        logic [3:0]  ftype;
        logic [1:0]  tt;
        logic [7:0]  hop_count;
        logic [3:0]  ttype;
        logic [15:0] source_id;
        logic [15:0] raw_bytes_3_4;
        logic [20:0] address;
        logic        word_pointer;
    } mec_packet_t;

    // error flags in one packet, bit order of the status register
    typedef struct packed {
        logic unsupported_transaction_flag;
        logic illegal_response_flag;
        logic illegal_transaction_flag;
    } mec_errors_t;

    // words loaded on capture
    typedef struct packed {
        logic [31:0] address_word;
        logic [31:0] source_id_word;
        logic [31:0] control_word;
    } mec_capture_t;

    // bus handshake states
    typedef enum logic [1:0] {
        MEC_BUS_IDLE = 2'b01,
        MEC_BUS_ACK  = 2'b10
    } mec_bus_state_t;

endpackage

// ===== hw/mec_decode.sv
// classifies an incoming packet and builds the capture words
`timescale 1ns/1ps
`include "mec_cfg.svh"

module mec_decode
    import mec_pkg::*;
(
    // incoming packet
    input  wire logic        pkt_valid,
    input  wire mec_packet_t pkt,
    // enable bits
    input  wire mec_errors_t enables,
    // results
    output      mec_errors_t detected,
    output      mec_errors_t enabled_hits,
    output      mec_capture_t capture
);

    logic terminating;
    logic tt_bad;

    // only maintenance traffic at hop count zero is examined
    assign terminating = pkt_valid
        && (pkt.ftype == `MEC_FTYPE_MAINT)
        && (pkt.hop_count == `MEC_HOP_TERMINATE);
    assign tt_bad = pkt.tt[1];

    // error classes
    always_comb begin
        detected = '0;
        detected.illegal_transaction_flag = terminating
            && ((pkt.ttype >= `MEC_TTYPE_FIRST_BAD) || tt_bad);
        detected.illegal_response_flag = terminating && !tt_bad
            && ((pkt.ttype == `MEC_TTYPE_RD_RESP)
             || (pkt.ttype == `MEC_TTYPE_WR_RESP));
        detected.unsupported_transaction_flag = terminating && !tt_bad
            && (pkt.ttype == `MEC_TTYPE_PORT_WR);
    end

    // per error gating by its enable bit
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_gate
            assign enabled_hits[g] = detected[g] && enables[g];
        end
    endgenerate

    // capture words, fields placed whatever the packet type
    always_comb begin
        capture = '0;
        capture.address_word[`MEC_ADDR_HI:`MEC_ADDR_LO] = pkt.address;
        capture.address_word[`MEC_WORD_POINTER_BIT] = pkt.word_pointer;
        if (tt_bad) begin
            capture.source_id_word[15:0] = pkt.raw_bytes_3_4;
        end else if (pkt.tt == `MEC_TT_LARGE) begin
            capture.source_id_word[15:0] = pkt.source_id;
        end else begin
            capture.source_id_word[`MEC_SRC_LSB_HI:`MEC_SRC_LSB_LO] =
                pkt.source_id[7:0];
        end
        capture.control_word[`MEC_FTYPE_HI:`MEC_FTYPE_LO] = pkt.ftype;
        capture.control_word[`MEC_TTYPE_HI:`MEC_TTYPE_LO] = pkt.ttype;
    end

endmodule // mec_decode

// ===== hw/mec_capture_bank.sv
// logical/transport error capture registers with avalon-mm access
`timescale 1ns/1ps
`include "mec_cfg.svh"

// Notes on behaviour
// - an enabled error loads all three capture registers then freezes them
// - only maintenance packets at hop count zero are examined
// - address goes to bits 8:28, word pointer to bit 30
// - with invalid tt the address position bits are captured as they are
// - port-writes and responses capture whatever sits at the address place
// - correctly formatted requests failing otherwise change no capture register
// - source id low byte in 24:31, high byte in 16:23 for large ids
// - undefined tt captures packet bytes 3 and 4 raw
// - format type in bits 0:3, transaction type in 4:7
// - transaction type is the four bits after the format type
// - captured format type of maintenance packets reads eight
// - illegal transaction for ttype 5..15 or tt 2/3 at hop zero
// - illegal response for any maintenance response at hop zero with tt 0/1
// - unsupported transaction for any port-write at hop zero with tt 0/1
// - each error's enable bit decides whether it locks and reports
module mec_capture_bank
    import mec_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // avalon-mm slave
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output      logic [31:0] avs_readdata,
    output      logic        avs_waitrequest,
    // packets reaching the logical layer
    input  wire logic        pkt_valid,
    input  wire mec_packet_t pkt,
    // status
    output      logic        capture_locked,
    output      logic        irq
);

    mec_bus_state_t state;
    mec_bus_state_t next_state;
    logic [31:0]    next_readdata;
    logic           next_waitrequest;
    logic [31:0]    enable_reg;
    logic [31:0]    addr_cap;
    logic [31:0]    source_id_low_byte_cap;
    logic [31:0]    ctrl_cap;
    logic [3:0]     int_status;
    logic [3:0]     int_mask;
    logic [31:0]    next_enable_reg;
    logic [31:0]    next_addr_cap;
    logic [31:0]    next_source_id_low_byte_cap;
    logic [31:0]    next_ctrl_cap;
    logic [3:0]     next_int_status;
    logic [3:0]     next_int_mask;
    logic           next_capture_locked;
    logic           next_irq;
    logic           wr_commit;
    logic [31:0]    wr_merged;
    logic           unlock_wr;
    logic           capture_fire;
    mec_errors_t    enables;
    mec_errors_t    detected;
    mec_errors_t    enabled_hits;
    mec_capture_t   capture;

    // merge write data with the current word under byte enables
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0]  be);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // address match of a register offset
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] ofs);
        return a == ofs;
    endfunction

    // enable bits taken from the enable register
    assign enables.illegal_transaction_flag   = enable_reg[`MEC_EN_ILL_TRANS];
    assign enables.illegal_response_flag      = enable_reg[`MEC_EN_ILL_RESP];
    assign enables.unsupported_transaction_flag =
        enable_reg[`MEC_EN_UNSUP_TRANS];

    // packet classifier
    mec_decode u_decode (
        .pkt_valid    (pkt_valid),
        .pkt          (pkt),
        .enables      (enables),
        .detected     (detected),
        .enabled_hits (enabled_hits),
        .capture      (capture)
    );

    // bus write takes effect on the edge where waitrequest is low
    assign wr_commit = avs_write && !avs_waitrequest;
    assign wr_merged = merge_bytes(32'h00000000, avs_writedata,
                                   avs_byteenable);
    assign unlock_wr = wr_commit && hit(avs_address, `MEC_OFS_CTRL_CAP)
                       && (wr_merged == `MEC_RST_WORD);
    // a new error captures when free, or in the cycle the lock is released
    assign capture_fire = (|enabled_hits)
                          && (!capture_locked || unlock_wr);

    // bus handshake: one wait cycle, then one acknowledged cycle
    always_comb begin
        next_state       = state;
        next_waitrequest = avs_waitrequest;
        next_readdata    = avs_readdata;
        case (state)
            MEC_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_state       = MEC_BUS_ACK;
                    next_waitrequest = 1'b0;
                    next_readdata    = 32'h00000000;
                    if (avs_read) begin
                        if (hit(avs_address, `MEC_OFS_ENABLE))
                            next_readdata = enable_reg;
                        else if (hit(avs_address, `MEC_OFS_ADDR_CAP))
                            next_readdata = addr_cap;
                        else if (hit(avs_address, `MEC_OFS_SOURCE_ID_LOW_BYTE_CAP))
                            next_readdata = source_id_low_byte_cap;
                        else if (hit(avs_address, `MEC_OFS_CTRL_CAP))
                            next_readdata = ctrl_cap;
                        else if (hit(avs_address, `MEC_OFS_INT_STATUS))
                            next_readdata = {28'h0000000, int_status};
                        else if (hit(avs_address, `MEC_OFS_INT_MASK))
                            next_readdata = {28'h0000000, int_mask};
                    end
                end
            end
            MEC_BUS_ACK: begin
                next_state       = MEC_BUS_IDLE;
                next_waitrequest = 1'b1;
            end
            default: begin
                next_state       = MEC_BUS_IDLE;
                next_waitrequest = 1'b1;
            end
        endcase
    end

    // bus handshake registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state           <= MEC_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            state           <= next_state;
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
        end
    end

    // register file next values; hardware capture wins over software
    always_comb begin
        next_enable_reg     = enable_reg;
        next_addr_cap       = addr_cap;
        next_source_id_low_byte_cap      = source_id_low_byte_cap;
        next_ctrl_cap       = ctrl_cap;
        next_int_mask       = int_mask;
        next_int_status     = int_status;
        next_capture_locked = capture_locked;
        if (wr_commit) begin
            if (hit(avs_address, `MEC_OFS_ENABLE))
                next_enable_reg = merge_bytes(enable_reg, avs_writedata,
                    avs_byteenable) & ((32'h1 << `MEC_EN_ILL_TRANS)
                    | (32'h1 << `MEC_EN_ILL_RESP)
                    | (32'h1 << `MEC_EN_UNSUP_TRANS));
            if (hit(avs_address, `MEC_OFS_ADDR_CAP))
                next_addr_cap = merge_bytes(addr_cap, avs_writedata,
                    avs_byteenable) & `MEC_ADDR_CAP_MASK;
            if (hit(avs_address, `MEC_OFS_SOURCE_ID_LOW_BYTE_CAP))
                next_source_id_low_byte_cap = merge_bytes(source_id_low_byte_cap, avs_writedata,
                    avs_byteenable) & `MEC_SOURCE_ID_LOW_BYTE_CAP_MASK;
            if (hit(avs_address, `MEC_OFS_CTRL_CAP))
                next_ctrl_cap = merge_bytes(ctrl_cap, avs_writedata,
                    avs_byteenable) & `MEC_CTRL_CAP_MASK;
            if (hit(avs_address, `MEC_OFS_INT_MASK))
                next_int_mask = avs_byteenable[0] ? avs_writedata[3:0]
                                                  : int_mask;
            if (hit(avs_address, `MEC_OFS_INT_STATUS)
                && avs_byteenable[0])
                next_int_status = int_status & ~avs_writedata[3:0];
        end
        if (unlock_wr)
            next_capture_locked = 1'b0;
        // enabled errors report, set wins over a same-cycle clear
        next_int_status[2:0] = next_int_status[2:0] | enabled_hits;
        if (capture_fire) begin
            next_addr_cap       = capture.address_word;
            next_source_id_low_byte_cap      = capture.source_id_word;
            next_ctrl_cap       = capture.control_word;
            next_capture_locked = 1'b1;
            next_int_status[3]  = 1'b1;
        end
        next_irq = |(int_status & int_mask);
    end

    // register file storage, all fields reset to zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            enable_reg     <= `MEC_RST_WORD;
            addr_cap       <= `MEC_RST_WORD;
            source_id_low_byte_cap      <= `MEC_RST_WORD;
            ctrl_cap       <= `MEC_RST_WORD;
            int_status     <= `MEC_RST_VEC;
            int_mask       <= `MEC_RST_VEC;
            capture_locked <= 1'b0;
            irq            <= 1'b0;
        end else begin
            enable_reg     <= next_enable_reg;
            addr_cap       <= next_addr_cap;
            source_id_low_byte_cap      <= next_source_id_low_byte_cap;
            ctrl_cap       <= next_ctrl_cap;
            int_status     <= next_int_status;
            int_mask       <= next_int_mask;
            capture_locked <= next_capture_locked;
            irq            <= next_irq;
        end
    end

    // checks on capture, freeze and reporting
    a_lock_on_capture: assert property (
        @(posedge clk_sys) disable iff (reset)
        capture_fire |=> capture_locked && int_status[3])
        else $error("capture did not lock the registers");

    a_frozen_holds: assert property (
        @(posedge clk_sys) disable iff (reset)
        capture_locked && !wr_commit |=> $stable(addr_cap)
            && $stable(source_id_low_byte_cap) && $stable(ctrl_cap))
        else $error("frozen capture registers changed");

    a_bypass_untouched: assert property (
        @(posedge clk_sys) disable iff (reset)
        pkt_valid && pkt.ftype != `MEC_FTYPE_MAINT && !wr_commit
        |=> $stable(ctrl_cap) && $stable(int_status))
        else $error("non-maintenance packet touched the bank");

    a_good_request_quiet: assert property (
        @(posedge clk_sys) disable iff (reset)
        pkt_valid && pkt.ttype < 4'h2 && !pkt.tt[1] && !wr_commit
        |=> $stable(addr_cap) && $stable(capture_locked))
        else $error("well formed request changed a capture register");

    a_address_fields: assert property (
        @(posedge clk_sys) disable iff (reset)
        capture_fire |=> addr_cap[23:3] == $past(pkt.address)
            && addr_cap[1] == $past(pkt.word_pointer))
        else $error("address or word pointer captured wrongly");

    a_source_small: assert property (
        @(posedge clk_sys) disable iff (reset)
        capture_fire && pkt.tt == 2'h0
        |=> source_id_low_byte_cap == {24'h000000, $past(pkt.source_id[7:0])})
        else $error("small source id captured wrongly");

    a_raw_bytes: assert property (
        @(posedge clk_sys) disable iff (reset)
        capture_fire && pkt.tt[1]
        |=> source_id_low_byte_cap[15:0] == $past(pkt.raw_bytes_3_4))
        else $error("raw bytes 3 and 4 not captured");

    a_type_fields: assert property (
        @(posedge clk_sys) disable iff (reset)
        capture_fire |=> ctrl_cap[31:24] == {$past(pkt.ftype),
            $past(pkt.ttype)} && ctrl_cap[31:28] == 4'h8)
        else $error("format or transaction type captured wrongly");

    a_response_flag: assert property (
        @(posedge clk_sys) disable iff (reset)
        pkt_valid && pkt.ftype == 4'h8 && pkt.hop_count == 8'h00
        && pkt.ttype == 4'h3 && !pkt.tt[1]
        && enable_reg[`MEC_EN_ILL_RESP] |=> int_status[1])
        else $error("illegal response not reported");

    a_reserved_zero: assert property (
        @(posedge clk_sys) disable iff (reset)
        (addr_cap & ~`MEC_ADDR_CAP_MASK) == 32'h0
        && (ctrl_cap & ~`MEC_CTRL_CAP_MASK) == 32'h0)
        else $error("reserved capture bits not zero");

    a_irq_follows: assert property (
        @(posedge clk_sys) disable iff (reset)
        ##1 irq == |($past(int_status) & $past(int_mask)))
        else $error("interrupt does not follow masked status");

    a_wait_single: assert property (
        @(posedge clk_sys) disable iff (reset)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

endmodule // mec_capture_bank

// ===== test/mec_pkt_source.sv
// behavioural link partner presenting packet headers of any format type
`timescale 1ns/1ps

module mec_pkt_source
    import mec_pkg::*;
(
    // clock
    input  wire logic        clk_sys,
    // packet header towards the logical layer
    output      logic        pkt_valid,
    output      mec_packet_t pkt
);
    // idle state at time zero
    initial begin
        pkt_valid = 1'b0;
        pkt       = '0;
    end

    // one header per call, taken at the next rising edge
    task automatic send(input mec_packet_t p);
        pkt       <= p;
        pkt_valid <= 1'b1;
        @(posedge clk_sys);
        pkt_valid <= 1'b0;
        pkt       <= ~p;  // stale header must not pass for the last one
    endtask
endmodule // mec_pkt_source

// ===== test/mec_capture_bank_tb.sv
// self-checking bench for the error capture bank
`timescale 1ns/1ps
`include "mec_cfg.svh"

module mec_capture_bank_tb
    import mec_pkg::*;
;
    logic              clk_sys        = 1'b0;
    logic              reset          = 1'b1;
    logic [15:0]       avs_address    = 16'h0000;
    logic              avs_read       = 1'b0;
    logic              avs_write      = 1'b0;
    logic [31:0]       avs_writedata  = 32'h00000000;
    logic [3:0]        avs_byteenable = 4'hf;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              pkt_valid;
    mec_packet_t       pkt;
    logic              capture_locked;
    logic              irq;
    int                failures = 0;
    int                checked  = 0;
    mec_packet_t       p;
    logic [3:0]        c_ty [7] = '{4'h5, 4'hf, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4};
    logic [1:0]        c_tt [7] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h1, 2'h1, 2'h1};
    logic [3:0]        c_st [7] = '{4'h9, 4'h9, 4'h9, 4'h9, 4'ha, 4'ha, 4'hc};
    logic [31:0]       e_sid;

    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;

    mec_capture_bank i_mec_capture_bank (
        .clk_sys        (clk_sys),
        .reset          (reset),
        .avs_address    (avs_address),
        .avs_read       (avs_read),
        .avs_write      (avs_write),
        .avs_writedata  (avs_writedata),
        .avs_byteenable (avs_byteenable),
        .avs_readdata   (avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .pkt_valid      (pkt_valid),
        .pkt            (pkt),
        .capture_locked (capture_locked),
        .irq            (irq)
    );

    mec_pkt_source i_mec_pkt_source (
        .clk_sys  (clk_sys),
        .pkt_valid(pkt_valid),
        .pkt      (pkt)
    );

    // verdict and end of run
    task automatic complete_run();
        if (failures == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // compare one value
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // hold the request until waitrequest is sampled low
    task automatic wait_ack();
        int n;
        n = 0;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 50) begin
                failures++;
                complete_run();
            end
            @(posedge clk_sys);
        end
    endtask

    // avalon-mm write of one word
    task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        wait_ack();
        avs_write     <= 1'b0;
        @(posedge clk_sys);  // one idle edge before the next request
    endtask

    // avalon-mm read of one word
    task automatic bus_rd(input logic [15:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read    <= 1'b1;
        wait_ack();
        d = avs_readdata;
        avs_read    <= 1'b0;
        @(posedge clk_sys);  // one idle edge before the next request
    endtask

    // read and compare
    task automatic rd_chk(input string name, input logic [15:0] a,
                          input logic [31:0] exp);
        logic [31:0] v;
        bus_rd(a, v);
        check(name, v, exp);
    endtask

    // build a header
    function automatic mec_packet_t mk(input logic [3:0] ft,
        input logic [1:0] tt, input logic [7:0] hop, input logic [3:0] ty,
        input logic [15:0] sid, input logic [20:0] adr);
        mec_packet_t q;
        q.ftype         = ft;
        q.tt            = tt;
        q.hop_count     = hop;
        q.ttype         = ty;
        q.source_id     = sid;
        q.raw_bytes_3_4 = ~sid;
        q.address       = adr;
        q.word_pointer  = adr[0];
        return q;
    endfunction

    // send a header and let capture and irq settle
    task automatic send_wait(input mec_packet_t q);
        i_mec_pkt_source.send(q);
        repeat (3) @(posedge clk_sys);
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        // reset values and unmapped place
        rd_chk("addr_rst", `MEC_OFS_ADDR_CAP, 32'h00000000);
        rd_chk("sid_rst", `MEC_OFS_SOURCE_ID_LOW_BYTE_CAP, 32'h00000000);
        rd_chk("ctrl_rst", `MEC_OFS_CTRL_CAP, 32'h00000000);
        rd_chk("unmapped", 16'h1020, 32'h00000000);
        // reserved bits drop writes
        bus_wr(`MEC_OFS_ADDR_CAP, 32'hffffffff);
        bus_wr(`MEC_OFS_SOURCE_ID_LOW_BYTE_CAP, 32'hffffffff);
        bus_wr(`MEC_OFS_CTRL_CAP, 32'hffffffff);
        rd_chk("addr_rsv", `MEC_OFS_ADDR_CAP, 32'h00fffffa);
        rd_chk("sid_rsv", `MEC_OFS_SOURCE_ID_LOW_BYTE_CAP, 32'h0000ffff);
        rd_chk("ctrl_rsv", `MEC_OFS_CTRL_CAP, 32'hff000000);
        bus_wr(`MEC_OFS_CTRL_CAP, 32'h00000000);
        // disabled error neither flags nor captures
        send_wait(mk(4'h8, 2'h1, 8'h00, 4'h5, 16'h1234, 21'h00abc));
        check("dis_lock", {31'h0, capture_locked}, 32'h0);
        rd_chk("dis_st", `MEC_OFS_INT_STATUS, 32'h00000000);
        // enable all errors, mask off
        bus_wr(`MEC_OFS_ENABLE, 32'h08c00000);
        // other format, nonzero hop, good request: no capture
        send_wait(mk(4'h5, 2'h1, 8'h00, 4'h5, 16'h1111, 21'h00001));
        send_wait(mk(4'h8, 2'h1, 8'h01, 4'h5, 16'h2222, 21'h00002));
        send_wait(mk(4'h8, 2'h1, 8'h00, 4'h0, 16'h3333, 21'h00003));
        check("skip_lock", {31'h0, capture_locked}, 32'h0);
        rd_chk("skip_sid", `MEC_OFS_SOURCE_ID_LOW_BYTE_CAP, 32'h0000ffff);
        // masked error: status set, irq quiet until unmasked
        send_wait(mk(4'h8, 2'h1, 8'h00, 4'h9, 16'h4444, 21'h00004));
        check("irq_mask", {31'h0, irq}, 32'h0);
        bus_wr(`MEC_OFS_INT_MASK, 32'h0000000f);
        repeat (2) @(posedge clk_sys);
        check("irq_unmask", {31'h0, irq}, 32'h1);
        bus_wr(`MEC_OFS_INT_STATUS, 32'h0000000f);
        bus_wr(`MEC_OFS_CTRL_CAP, 32'h00000000);
        repeat (2) @(posedge clk_sys);
        check("irq_clr", {31'h0, irq}, 32'h0);
        check("unlock0", {31'h0, capture_locked}, 32'h0);
        // every error kind and tt code
        for (int i = 0; i < 7; i++) begin
            p = mk(4'h8, c_tt[i], 8'h00, c_ty[i], 16'ha55a ^ 16'(i),
                   21'h1f0f0f ^ 21'(i));
            case (c_tt[i])
                2'h0:    e_sid = {24'h0, p.source_id[7:0]};
                2'h1:    e_sid = {16'h0, p.source_id};
                default: e_sid = {16'h0, p.raw_bytes_3_4};
            endcase
            send_wait(p);
            check("lock", {31'h0, capture_locked}, 32'h1);
            check("irq", {31'h0, irq}, 32'h1);
            rd_chk("addr", `MEC_OFS_ADDR_CAP,
                   {8'h0, p.address, 1'b0, p.word_pointer, 1'b0});
            rd_chk("sid", `MEC_OFS_SOURCE_ID_LOW_BYTE_CAP, e_sid);
            rd_chk("ctrl", `MEC_OFS_CTRL_CAP,
                   {4'h8, c_ty[i], 24'h0});
            // second enabled error while frozen
            send_wait(mk(4'h8, 2'h1, 8'h00, 4'h6, 16'h0f0f, 21'h0abcd));
            rd_chk("frozen", `MEC_OFS_CTRL_CAP,
                   {4'h8, c_ty[i], 24'h0});
            rd_chk("status", `MEC_OFS_INT_STATUS,
                   {28'h0, c_st[i] | 4'h1});
            // nonzero write keeps the lock, zero releases it
            bus_wr(`MEC_OFS_CTRL_CAP, 32'h01000000);
            check("keep", {31'h0, capture_locked}, 32'h1);
            bus_wr(`MEC_OFS_INT_STATUS, 32'h0000000f);
            bus_wr(`MEC_OFS_CTRL_CAP, 32'h00000000);
            rd_chk("ctrl_clr", `MEC_OFS_CTRL_CAP, 32'h00000000);
            check("unlock", {31'h0, capture_locked}, 32'h0);
        end
        complete_run();
    end
endmodule // mec_capture_bank_tb
